//--- pkg/i2c_flags_pkg.sv
// constants shared by the raw event and status flag block
package i2c_flags_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int CAUSE_W = 16;
  localparam int TX_ENTRY_W = 9;
  localparam int RX_BYTE_W = 8;
  localparam int LEVEL_W = 6;
  localparam int THRESH_W = 5;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_DATA_CMD = 32'h5000_1310;
  localparam logic [ADDR_W-1:0] ADDR_MASKED_STAT = 32'h5000_132C;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_MASK = 32'h5000_1330;
  localparam logic [ADDR_W-1:0] ADDR_RAW_FLAGS = 32'h5000_1334;
  localparam logic [ADDR_W-1:0] ADDR_SEND_THRESH = 32'h5000_133C;
  localparam logic [ADDR_W-1:0] ADDR_ALL_CLEAR = 32'h5000_1340;
  localparam logic [ADDR_W-1:0] ADDR_READ_PEND_CLEAR = 32'h5000_1350;
  localparam logic [ADDR_W-1:0] ADDR_ABORT_CLEAR = 32'h5000_1354;
  localparam logic [ADDR_W-1:0] ADDR_BUSY_CLEAR = 32'h5000_135C;
  localparam logic [ADDR_W-1:0] ADDR_BROADCAST_CLEAR = 32'h5000_1368;
  localparam logic [ADDR_W-1:0] ADDR_CONTROLLER_ON = 32'h5000_136C;
  localparam logic [ADDR_W-1:0] ADDR_ABORT_CAUSE = 32'h5000_1380;

  // bit positions in the raw and masked flag registers, plus the controller on enable bit
  localparam int BIT_BROADCAST = 11;
  localparam int BIT_START = 10;
  localparam int BIT_STOP = 9;
  localparam int BIT_BUSY = 8;
  localparam int BIT_TX_DONE = 7;
  localparam int BIT_ABORTED = 6;
  localparam int BIT_READ_PEND = 5;
  localparam int BIT_TX_EMPTY = 4;
  localparam int BIT_TX_OVER = 3;
  localparam int BIT_ENABLE = 0;

  localparam logic [REG_W-1:0] MASK_RESET = 16'h08FF;
  localparam logic [REG_W-1:0] LIVE_FLAGS = 16'h0FF8;
  localparam logic [LEVEL_W-1:0] FIFO_DEPTH = 6'h20;
  localparam logic [THRESH_W-1:0] THRESH_MAX = 5'h1F;
  localparam logic [LEVEL_W-1:0] LEVEL_ONE = 6'h01;

  // link event slots crossing by toggle
  localparam int EV_START = 0;
  localparam int EV_STOP = 1;
  localparam int EV_BROADCAST = 2;
  localparam int EV_TX_NACK = 3;
  localparam int EV_ABORT = 4;
  localparam int EV_READ_REQ = 5;
  localparam int EV_RX_BYTE = 6;
  localparam int EV_TX_POP = 7;
  localparam int NUM_EV = 8;

endpackage : i2c_flags_pkg

//--- logic/i2c_raw_event_status.sv
// raw event and status flags of the i2c controller with apb register access
`timescale 1ns/1ps

// What this block does
// (RL1) Broadcast flag sets only on an acknowledged general call address.
// (RL2) Broadcast flag holds until disable or read of its clear register.
// (RL3) Bytes following an acknowledged general call go to the receive buffer.
// (RL4) Start or repeated start on the bus sets a flag, master or slave.
// (RL5) Stop on the bus sets a flag, master or slave.
// (RL6) Busy flag captures activity; cleared by disable, clear reads or reset.
// (RL7) As slave transmitter, a master nack sets the transmit-done flag.
// (RL8) Transmit abort sets the aborted flag and records its cause.
// (RL9) While aborted, transmit FIFO stays flushed; accepts after clear read.
// (RL10) Slave read request from a remote master sets the read pending flag.
// (RL11) While read pending, SCL is held low to stretch the bus.
// (RL12) Processor services a read request by writing the byte command port.
// (RL13) Read pending flag drops right after its clear register is read.
// (RL14) Transmit empty flag follows level at or below the threshold.
// (RL15) Disabled: FIFO flushed; empty flag follows engine activity.
// (RL16) A command write with 32 entries queued sets the overflow flag.
// (RL17) Overflow holds after disable until internal enable drops.
// (RL18) Mask bits gate raw flags onto the masked status.
// (RL19) Threshold is five bits; 0 means zero entries, 31 means 32.
// (RL20) Combined clear read clears software flags and the abort cause.
// (RL21) Reserved raw bits read zero; all flags reset to zero.
module i2c_raw_event_status (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic linkClk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [i2c_flags_pkg::ADDR_W-1:0] paddr,
  input wire logic [i2c_flags_pkg::DATA_W-1:0] pwdata,
  output logic [i2c_flags_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic linkStartSeen,
  input wire logic linkStopSeen,
  input wire logic linkBroadcastAcked,
  input wire logic linkSlaveTxNack,
  input wire logic linkSendAborted,
  input wire logic [i2c_flags_pkg::CAUSE_W-1:0] linkAbortCause,
  input wire logic linkReadRequest,
  input wire logic linkRxByteValid,
  input wire logic [i2c_flags_pkg::RX_BYTE_W-1:0] linkRxByte,
  input wire logic linkTxPop,
  input wire logic linkEngineBusy,
  output logic sclOut,
  output logic sclOe,
  output logic txPush,
  output logic [i2c_flags_pkg::TX_ENTRY_W-1:0] txPushData,
  output logic txFlush,
  output logic rxPush,
  output logic [i2c_flags_pkg::RX_BYTE_W-1:0] rxData,
  output logic controllerOnInternal
);

  function automatic logic regHit(
    input logic strobe,
    input logic [i2c_flags_pkg::ADDR_W-1:0] addr,
    input logic [i2c_flags_pkg::ADDR_W-1:0] target
  );
    regHit = strobe && (addr == target);
  endfunction : regHit

  // ---------------- link domain ----------------
  logic [i2c_flags_pkg::NUM_EV-1:0] linkEvents;
  logic [i2c_flags_pkg::NUM_EV-1:0] evToggle_q, evToggle_d;
  logic [i2c_flags_pkg::CAUSE_W-1:0] causeHold_q, causeHold_d;
  logic [i2c_flags_pkg::RX_BYTE_W-1:0] rxHold_q, rxHold_d;
  logic pendSync1_q, pendSync1_d, pendSync2_q, pendSync2_d;
  logic sclOe_q, sclOe_d;
  logic readPending_q;

  always_comb begin
    linkEvents = '0;
    linkEvents[i2c_flags_pkg::EV_START] = linkStartSeen;
    linkEvents[i2c_flags_pkg::EV_STOP] = linkStopSeen;
    linkEvents[i2c_flags_pkg::EV_BROADCAST] = linkBroadcastAcked;
    linkEvents[i2c_flags_pkg::EV_TX_NACK] = linkSlaveTxNack;
    linkEvents[i2c_flags_pkg::EV_ABORT] = linkSendAborted;
    linkEvents[i2c_flags_pkg::EV_READ_REQ] = linkReadRequest;
    linkEvents[i2c_flags_pkg::EV_RX_BYTE] = linkRxByteValid;
    linkEvents[i2c_flags_pkg::EV_TX_POP] = linkTxPop;
  end

  // payloads are held until the next event of their kind, so the core
  // samples them stable; events of one kind need a few link cycles apart
  always_comb begin
    evToggle_d = evToggle_q ^ linkEvents;
    causeHold_d = linkSendAborted ? linkAbortCause : causeHold_q;
    rxHold_d = linkRxByteValid ? linkRxByte : rxHold_q;
    pendSync1_d = readPending_q;
    pendSync2_d = pendSync1_q;
    sclOe_d = pendSync2_q; // [RL11]
  end

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      evToggle_q <= '0;
      causeHold_q <= '0;
      rxHold_q <= '0;
      pendSync1_q <= 1'b0;
      pendSync2_q <= 1'b0;
      sclOe_q <= 1'b0;
    end else begin
      evToggle_q <= evToggle_d;
      causeHold_q <= causeHold_d;
      rxHold_q <= rxHold_d;
      pendSync1_q <= pendSync1_d;
      pendSync2_q <= pendSync2_d;
      sclOe_q <= sclOe_d;
    end
  end

  // open drain: the pin only ever pulls low
  assign sclOut = 1'b0;
  assign sclOe = sclOe_q;

  // ---------------- crossing into core ----------------
  logic [i2c_flags_pkg::NUM_EV-1:0] evSync1_q, evSync1_d;
  logic [i2c_flags_pkg::NUM_EV-1:0] evSync2_q, evSync2_d;
  logic [i2c_flags_pkg::NUM_EV-1:0] evSeen_q, evSeen_d;
  logic [i2c_flags_pkg::NUM_EV-1:0] ev;
  logic busySync1_q, busySync1_d, busySync2_q, busySync2_d;

  always_comb begin
    evSync1_d = evToggle_q;
    evSync2_d = evSync1_q;
    evSeen_d = evSync2_q;
    busySync1_d = linkEngineBusy;
    busySync2_d = busySync1_q;
    ev = evSync2_q ^ evSeen_q;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evSync1_q <= '0;
      evSync2_q <= '0;
      evSeen_q <= '0;
      busySync1_q <= 1'b0;
      busySync2_q <= 1'b0;
    end else begin
      evSync1_q <= evSync1_d;
      evSync2_q <= evSync2_d;
      evSeen_q <= evSeen_d;
      busySync1_q <= busySync1_d;
      busySync2_q <= busySync2_d;
    end
  end

  // ---------------- core domain ----------------
  logic [i2c_flags_pkg::REG_W-1:0] mask_q, mask_d;
  logic [i2c_flags_pkg::THRESH_W-1:0] thresh_q, thresh_d;
  logic enable_q, enable_d;
  logic broadcast_q, broadcast_d, start_q, start_d, stop_q, stop_d;
  logic busyFlag_q, busyFlag_d, txDone_q, txDone_d, aborted_q, aborted_d;
  logic readPending_d, overflow_q, overflow_d;
  logic [i2c_flags_pkg::CAUSE_W-1:0] cause_q, cause_d;
  logic [i2c_flags_pkg::LEVEL_W-1:0] level_q, level_d;
  logic [i2c_flags_pkg::DATA_W-1:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic txPush_q, txPush_d, txFlush_q, txFlush_d, rxPush_q, rxPush_d;
  logic [i2c_flags_pkg::TX_ENTRY_W-1:0] txData_q, txData_d;
  logic [i2c_flags_pkg::RX_BYTE_W-1:0] rxData_q, rxData_d;
  logic ctrlOn_q, ctrlOn_d;

  logic setup, rdStb, wrStb, clrAll, mapped, txEmpty, accept, pop;
  logic [i2c_flags_pkg::REG_W-1:0] rawFlags;

  always_comb begin
    setup = psel && !penable;
    rdStb = setup && !pwrite;
    wrStb = setup && pwrite;
    clrAll = regHit(rdStb, paddr, i2c_flags_pkg::ADDR_ALL_CLEAR); // [RL20]
    mapped = (paddr == i2c_flags_pkg::ADDR_DATA_CMD)
          || (paddr == i2c_flags_pkg::ADDR_MASKED_STAT)
          || (paddr == i2c_flags_pkg::ADDR_EVENT_MASK)
          || (paddr == i2c_flags_pkg::ADDR_RAW_FLAGS)
          || (paddr == i2c_flags_pkg::ADDR_SEND_THRESH)
          || (paddr == i2c_flags_pkg::ADDR_ALL_CLEAR)
          || (paddr == i2c_flags_pkg::ADDR_READ_PEND_CLEAR)
          || (paddr == i2c_flags_pkg::ADDR_ABORT_CLEAR)
          || (paddr == i2c_flags_pkg::ADDR_BUSY_CLEAR)
          || (paddr == i2c_flags_pkg::ADDR_BROADCAST_CLEAR)
          || (paddr == i2c_flags_pkg::ADDR_CONTROLLER_ON)
          || (paddr == i2c_flags_pkg::ADDR_ABORT_CAUSE);
    // threshold 31 stands for 32 entries, i.e. the whole depth
    if (enable_q) begin
      txEmpty = (level_q <= {1'b0, thresh_q})
             || (thresh_q == i2c_flags_pkg::THRESH_MAX); // [RL14] [RL19]
    end else begin
      txEmpty = busySync2_q; // [RL15]
    end
    rawFlags = '0; // [RL21]
    rawFlags[i2c_flags_pkg::BIT_BROADCAST] = broadcast_q;
    rawFlags[i2c_flags_pkg::BIT_START] = start_q;
    rawFlags[i2c_flags_pkg::BIT_STOP] = stop_q;
    rawFlags[i2c_flags_pkg::BIT_BUSY] = busyFlag_q;
    rawFlags[i2c_flags_pkg::BIT_TX_DONE] = txDone_q;
    rawFlags[i2c_flags_pkg::BIT_ABORTED] = aborted_q;
    rawFlags[i2c_flags_pkg::BIT_READ_PEND] = readPending_q;
    rawFlags[i2c_flags_pkg::BIT_TX_EMPTY] = txEmpty;
    rawFlags[i2c_flags_pkg::BIT_TX_OVER] = overflow_q;
  end

  always_comb begin
    mask_d = mask_q;
    thresh_d = thresh_q;
    enable_d = enable_q;
    if (regHit(wrStb, paddr, i2c_flags_pkg::ADDR_EVENT_MASK)) begin
      mask_d = pwdata[i2c_flags_pkg::REG_W-1:0] & i2c_flags_pkg::LIVE_FLAGS;
    end
    if (regHit(wrStb, paddr, i2c_flags_pkg::ADDR_SEND_THRESH)) begin
      // five bits cannot exceed the depth, so the clamp is implicit
      thresh_d = pwdata[i2c_flags_pkg::THRESH_W-1:0]; // [RL19]
    end
    if (regHit(wrStb, paddr, i2c_flags_pkg::ADDR_CONTROLLER_ON)) begin
      enable_d = pwdata[i2c_flags_pkg::BIT_ENABLE];
    end
    ctrlOn_d = enable_q || busySync2_q;

    // set always wins over a clear in the same cycle
    broadcast_d = ev[i2c_flags_pkg::EV_BROADCAST] || (broadcast_q && enable_q
      && !regHit(rdStb, paddr, i2c_flags_pkg::ADDR_BROADCAST_CLEAR)
      && !clrAll); // [RL1] [RL2]
    start_d = ev[i2c_flags_pkg::EV_START] || (start_q && !clrAll); // [RL4]
    stop_d = ev[i2c_flags_pkg::EV_STOP] || (stop_q && !clrAll); // [RL5]
    busyFlag_d = busySync2_q || (busyFlag_q && enable_q
      && !regHit(rdStb, paddr, i2c_flags_pkg::ADDR_BUSY_CLEAR)
      && !clrAll); // [RL6]
    txDone_d = ev[i2c_flags_pkg::EV_TX_NACK] || (txDone_q && !clrAll); // [RL7]
    aborted_d = ev[i2c_flags_pkg::EV_ABORT] || (aborted_q
      && !regHit(rdStb, paddr, i2c_flags_pkg::ADDR_ABORT_CLEAR)
      && !clrAll); // [RL8]
    readPending_d = ev[i2c_flags_pkg::EV_READ_REQ] || (readPending_q
      && !regHit(rdStb, paddr, i2c_flags_pkg::ADDR_READ_PEND_CLEAR)
      && !clrAll); // [RL10] [RL13]
    if (ev[i2c_flags_pkg::EV_ABORT]) begin
      cause_d = causeHold_q; // [RL8]
    end else if (clrAll) begin
      cause_d = '0; // [RL20]
    end else begin
      cause_d = cause_q;
    end

    // the command port: serviced read requests land here too
    accept = regHit(wrStb, paddr, i2c_flags_pkg::ADDR_DATA_CMD)
          && enable_q && !aborted_q; // [RL9] [RL12]
    pop = ev[i2c_flags_pkg::EV_TX_POP] && (level_q != '0);
    overflow_d = (accept && (level_q == i2c_flags_pkg::FIFO_DEPTH))
      || (overflow_q && ctrlOn_q && !clrAll); // [RL16] [RL17]
    txPush_d = accept && (level_q != i2c_flags_pkg::FIFO_DEPTH);
    txData_d = txPush_d ? pwdata[i2c_flags_pkg::TX_ENTRY_W-1:0] : txData_q;
    txFlush_d = !enable_q || aborted_q; // [RL9] [RL15]
    if (txFlush_d) begin
      level_d = '0; // [RL9]
    end else if (txPush_d && !pop) begin
      level_d = level_q + i2c_flags_pkg::LEVEL_ONE;
    end else if (pop && !txPush_d) begin
      level_d = level_q - i2c_flags_pkg::LEVEL_ONE;
    end else begin
      level_d = level_q;
    end

    // every received byte, broadcast ones included, goes to the rx buffer
    rxPush_d = ev[i2c_flags_pkg::EV_RX_BYTE]; // [RL3]
    rxData_d = rxPush_d ? rxHold_q : rxData_q;

    pready_d = setup;
    pslverr_d = setup && !mapped;
    prdata_d = '0;
    if (regHit(rdStb, paddr, i2c_flags_pkg::ADDR_RAW_FLAGS)) begin
      prdata_d[i2c_flags_pkg::REG_W-1:0] = rawFlags;
    end else if (regHit(rdStb, paddr, i2c_flags_pkg::ADDR_MASKED_STAT)) begin
      prdata_d[i2c_flags_pkg::REG_W-1:0] = rawFlags & mask_q; // [RL18]
    end else if (regHit(rdStb, paddr, i2c_flags_pkg::ADDR_EVENT_MASK)) begin
      prdata_d[i2c_flags_pkg::REG_W-1:0] = mask_q;
    end else if (regHit(rdStb, paddr, i2c_flags_pkg::ADDR_SEND_THRESH)) begin
      prdata_d[i2c_flags_pkg::THRESH_W-1:0] = thresh_q;
    end else if (regHit(rdStb, paddr, i2c_flags_pkg::ADDR_CONTROLLER_ON)) begin
      prdata_d[i2c_flags_pkg::BIT_ENABLE] = enable_q;
    end else if (regHit(rdStb, paddr, i2c_flags_pkg::ADDR_ABORT_CAUSE)) begin
      prdata_d[i2c_flags_pkg::CAUSE_W-1:0] = cause_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= i2c_flags_pkg::MASK_RESET;
      thresh_q <= '0;
      enable_q <= 1'b0;
      ctrlOn_q <= 1'b0;
      broadcast_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      busyFlag_q <= 1'b0;
      txDone_q <= 1'b0;
      aborted_q <= 1'b0;
      readPending_q <= 1'b0;
      overflow_q <= 1'b0;
      cause_q <= '0;
      level_q <= '0;
      txPush_q <= 1'b0;
      txData_q <= '0;
      txFlush_q <= 1'b1;
      rxPush_q <= 1'b0;
      rxData_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      mask_q <= mask_d;
      thresh_q <= thresh_d;
      enable_q <= enable_d;
      ctrlOn_q <= ctrlOn_d;
      broadcast_q <= broadcast_d;
      start_q <= start_d;
      stop_q <= stop_d;
      busyFlag_q <= busyFlag_d;
      txDone_q <= txDone_d;
      aborted_q <= aborted_d;
      readPending_q <= readPending_d;
      overflow_q <= overflow_d;
      cause_q <= cause_d;
      level_q <= level_d;
      txPush_q <= txPush_d;
      txData_q <= txData_d;
      txFlush_q <= txFlush_d;
      rxPush_q <= rxPush_d;
      rxData_q <= rxData_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign txPush = txPush_q;
  assign txPushData = txData_q;
  assign txFlush = txFlush_q;
  assign rxPush = rxPush_q;
  assign rxData = rxData_q;
  assign controllerOnInternal = ctrlOn_q;

endmodule : i2c_raw_event_status

//--- bench/raw_flags_checker.sv
// port assertions for the raw event and status flag block
`timescale 1ns/1ps
module raw_flags_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic linkClk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic linkReadRequest,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic txPush,
  input wire logic rxPush,
  input wire logic [8:0] txPushData
);
  sequence readAt(logic [31:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence cmdWrite;
    psel && !penable && pwrite && paddr == i2c_flags_pkg::ADDR_DATA_CMD;
  endsequence
  ready_after_setup_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) psel && !penable |=> pready) else $error("no ready");
  ready_single_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pready |=> !pready) else $error("ready too long");
  error_with_ready_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) pslverr |-> pready) else $error("lone slverr");
  push_from_cmd_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) txPush |-> $past(psel && !penable && pwrite
    && paddr == i2c_flags_pkg::ADDR_DATA_CMD)) else $error("stray push");
  push_data_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) cmdWrite ##1 txPush |->
    txPushData == $past(pwdata[8:0])) else $error("push data");
  raw_reserved_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) readAt(i2c_flags_pkg::ADDR_RAW_FLAGS) ##1 pready
    |-> prdata[31:12] == 20'h00000 && prdata[2:0] == 3'h0)
    else $error("reserved bits set");
  stretch_release_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) readAt(i2c_flags_pkg::ADDR_READ_PEND_CLEAR)
    |-> ##[1:200] !sclOe) else $error("stretch kept");
  stretch_on_req_a: assert property (@(posedge linkClk)
    disable iff (!rst_n) linkReadRequest |-> ##[1:10] sclOe)
    else $error("no stretch");
  scl_low_only_a: assert property (@(posedge linkClk)
    disable iff (!rst_n) sclOut == 1'b0) else $error("scl driven high");
  rx_single_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) rxPush |=> !rxPush) else $error("double rx push");
endmodule : raw_flags_checker

bind i2c_raw_event_status raw_flags_checker chk_u (.*);

//--- bench/link_partner.sv
// behavioural remote bus side: link events on linkClk
`timescale 1ns/1ps
module link_partner (
  input wire logic linkClk,
  output logic [7:0] ev,
  output logic [15:0] cause,
  output logic [7:0] rxByte,
  output logic busy
);
  initial begin
    ev = 8'h00;
    cause = 16'hFFFF;
    rxByte = 8'hFF;
    busy = 1'b0;
  end
  // events kept four link cycles apart so payloads never merge
  task automatic send(input int slot, input logic [15:0] pay);
    @(posedge linkClk) #1;
    ev[slot] = 1'b1;
    cause = pay;
    rxByte = pay[7:0];
    @(posedge linkClk) #1;
    ev[slot] = 1'b0;
    cause = ~pay;
    rxByte = ~pay[7:0];
    repeat (2) @(posedge linkClk);
  endtask : send
  task automatic setBusy(input logic b);
    @(posedge linkClk) #1;
    busy = b;
  endtask : setBusy
endmodule : link_partner

//--- bench/testbench.sv
// self-checking bench for the raw event and status flag block
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0;
  logic linkClk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, sclOut, sclOe, txPush, txFlush, rxPush, onInt;
  logic txPop, busy;
  logic [8:0] txPushData, lastPush;
  logic [7:0] rxData, lastRx, ev, rxByte;
  logic [15:0] cause;
  int n_errors = 0;
  int checked = 0;
  int nPush = 0;
  int n0;
  always #2.5 core_clk = ~core_clk;
  initial begin
    #1.3;
    forever #40 linkClk = ~linkClk;
  end
  link_partner partner_u (.linkClk(linkClk), .ev(ev), .cause(cause),
    .rxByte(rxByte), .busy(busy));
  i2c_raw_event_status dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .linkClk(linkClk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .linkStartSeen(ev[0]), .linkStopSeen(ev[1]),
    .linkBroadcastAcked(ev[2]), .linkSlaveTxNack(ev[3]),
    .linkSendAborted(ev[4]), .linkAbortCause(cause),
    .linkReadRequest(ev[5]), .linkRxByteValid(ev[6]), .linkRxByte(rxByte),
    .linkTxPop(ev[7]), .linkEngineBusy(busy), .sclOut(sclOut),
    .sclOe(sclOe), .txPush(txPush), .txPushData(txPushData),
    .txFlush(txFlush), .rxPush(rxPush), .rxData(rxData),
    .controllerOnInternal(onInt));
  always @(posedge core_clk) begin
    if (txPush === 1'b1) begin
      nPush++;
      lastPush = txPushData;
    end
    if (rxPush === 1'b1) lastRx = rxData;
  end
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chkReg
  task automatic chkPin(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: pin %b want %b", $time, got, exp);
    end
  endtask : chkPin
  // setup, then access phase where the registered answer is looked at
  task automatic apb(input logic wr, input logic [31:0] a,
      input logic [31:0] d);
    @(posedge core_clk) #1;
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(posedge core_clk) #1;
    penable = 1'b1;
    chkPin(pready, 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge core_clk) #1;
    psel = 1'b0;
    penable = 1'b0;
  endtask : apb
  task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chkReg(rd, exp);
  endtask : rdChk
  task automatic tReset;
    chkPin(txFlush, 1'b1);
    rdChk(i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000000);
    rdChk(i2c_flags_pkg::ADDR_EVENT_MASK, 32'h000008FF);
    apb(1'b0, 32'h50001FFC, 32'h00000000);
    chkPin(err, 1'b1);
  endtask : tReset
  task automatic tFrame;
    apb(1'b1, i2c_flags_pkg::ADDR_CONTROLLER_ON, 32'h00000001);
    rdChk(i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000010);
    partner_u.setBusy(1'b1);
    partner_u.send(i2c_flags_pkg::EV_START, 16'h0000);
    partner_u.send(i2c_flags_pkg::EV_BROADCAST, 16'h0000);
    partner_u.send(i2c_flags_pkg::EV_RX_BYTE, 16'h005A);
    partner_u.send(i2c_flags_pkg::EV_TX_NACK, 16'h0000);
    partner_u.send(i2c_flags_pkg::EV_STOP, 16'h0000);
    partner_u.setBusy(1'b0);
    repeat (12) @(posedge core_clk);
    rdChk(i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000F90);
    chkReg({24'h000000, lastRx}, 32'h0000005A);
    rdChk(i2c_flags_pkg::ADDR_MASKED_STAT, 32'h00000890);
    // only bits 11:3 of the mask are writable
    apb(1'b1, i2c_flags_pkg::ADDR_EVENT_MASK, 32'h0000FFFF);
    rdChk(i2c_flags_pkg::ADDR_EVENT_MASK, 32'h00000FF8);
    rdChk(i2c_flags_pkg::ADDR_MASKED_STAT, 32'h00000F90);
    rdChk(i2c_flags_pkg::ADDR_BROADCAST_CLEAR, 32'h00000000);
    rdChk(i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000790);
    apb(1'b0, i2c_flags_pkg::ADDR_BUSY_CLEAR, 32'h00000000);
    rdChk(i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000690);
    apb(1'b0, i2c_flags_pkg::ADDR_ALL_CLEAR, 32'h00000000);
    rdChk(i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000010);
  endtask : tFrame
  task automatic tReadReq;
    partner_u.send(i2c_flags_pkg::EV_READ_REQ, 16'h0000);
    repeat (4) @(posedge linkClk);
    rdChk(i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000030);
    chkPin(sclOe, 1'b1);
    apb(1'b1, i2c_flags_pkg::ADDR_DATA_CMD, 32'h000001A5);
    chkReg({23'h000000, lastPush}, 32'h000001A5);
    apb(1'b0, i2c_flags_pkg::ADDR_READ_PEND_CLEAR, 32'h00000000);
    rdChk(i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000000);
    partner_u.send(i2c_flags_pkg::EV_TX_POP, 16'h0000);
    repeat (4) @(posedge linkClk);
    chkPin(sclOe, 1'b0);
  endtask : tReadReq
  task automatic tFill;
    apb(1'b1, i2c_flags_pkg::ADDR_SEND_THRESH, 32'h00000002);
    n0 = nPush;
    for (int i = 1; i <= 33; i++) begin
      apb(1'b1, i2c_flags_pkg::ADDR_DATA_CMD, 32'h00000100 + i);
      if (i == 2) rdChk(i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000010);
      if (i == 3) rdChk(i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000000);
    end
    chkReg(32'(nPush - n0), 32'h00000020);
    rdChk(i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000008);
    apb(1'b1, i2c_flags_pkg::ADDR_SEND_THRESH, 32'h0000001F);
    rdChk(i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000018);
  endtask : tFill
  task automatic tDisable;
    partner_u.setBusy(1'b1);
    partner_u.send(i2c_flags_pkg::EV_BROADCAST, 16'h0000);
    repeat (12) @(posedge core_clk);
    rdChk(i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000918);
    apb(1'b1, i2c_flags_pkg::ADDR_CONTROLLER_ON, 32'h00000000);
    repeat (12) @(posedge core_clk);
    apb(1'b0, i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000000);
    chkReg(rd & 32'h00000818, 32'h00000018);
    chkPin(txFlush, 1'b1);
    chkPin(onInt, 1'b1);
    partner_u.setBusy(1'b0);
    repeat (12) @(posedge core_clk);
    apb(1'b0, i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000000);
    chkReg(rd & 32'h00000018, 32'h00000000);
    chkPin(onInt, 1'b0);
  endtask : tDisable
  task automatic tAbort;
    apb(1'b1, i2c_flags_pkg::ADDR_CONTROLLER_ON, 32'h00000001);
    partner_u.send(i2c_flags_pkg::EV_ABORT, 16'h0ABC);
    repeat (12) @(posedge core_clk);
    apb(1'b0, i2c_flags_pkg::ADDR_RAW_FLAGS, 32'h00000000);
    chkReg(rd & 32'h00000040, 32'h00000040);
    rdChk(i2c_flags_pkg::ADDR_ABORT_CAUSE, 32'h00000ABC);
    chkPin(txFlush, 1'b1);
    n0 = nPush;
    apb(1'b1, i2c_flags_pkg::ADDR_DATA_CMD, 32'h00000011);
    chkReg(32'(nPush - n0), 32'h00000000);
    apb(1'b0, i2c_flags_pkg::ADDR_ABORT_CLEAR, 32'h00000000);
    apb(1'b1, i2c_flags_pkg::ADDR_DATA_CMD, 32'h00000022);
    chkReg(32'(nPush - n0), 32'h00000001);
    partner_u.send(i2c_flags_pkg::EV_ABORT, 16'h0123);
    repeat (12) @(posedge core_clk);
    apb(1'b0, i2c_flags_pkg::ADDR_ALL_CLEAR, 32'h00000000);
    rdChk(i2c_flags_pkg::ADDR_ABORT_CAUSE, 32'h00000000);
  endtask : tAbort
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    tReset();
    tFrame();
    tReadReq();
    tFill();
    tDisable();
    tAbort();
    summarize();
  end
endmodule : testbench
